// >>> design/adc_seq_pkg.sv
// Shared constants and types for the converter sequencer.
// Assumes a single 50 MHz core clock feeding every file that imports it.
package adc_seq_pkg;

  // Core clock period in nanoseconds.
  localparam int CORE_CLK_NS = 20;

  // Start request to sample-and-hold delay, in core clock periods.
  localparam int SOC_DELAY_CYC = 3;
  // End of conversion to result load, in core clock periods.
  localparam int EOC_DELAY_CYC = 2;
  // Completion flag to interrupt delay, in core clock periods.
  localparam int IRQ_DELAY_CYC = 2;

  // Sample-and-hold and conversion lengths, in converter clock periods.
  localparam int SH_TICKS = 3;
  localparam int CONV_TICKS = 10;

  // Shortest converter clock period and the divide it needs at least.
  localparam int ADC_CLK_MIN_NS = 50;
  localparam int ADC_DIV_MIN = (ADC_CLK_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

  // Shortest whole sequence, from start to result load.
  localparam int SEQ_MIN_NS = 900;
  localparam int SEQ_MIN_CYC = (SEQ_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

  // Analog settling after power-up, kept by the controlling software.
  localparam int SETTLE_US = 10;

  // Widths of the result, channel number and prescaler setting.
  localparam int RESULT_W = 10;
  localparam int CHAN_W = 3;
  localparam int PRESCALE_W = 4;
  localparam int CNT_W = 8;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START_DLY = 3'h1,
    ST_SAMPLE = 3'h2,
    ST_CONVERT = 3'h3,
    ST_EOC_DLY = 3'h4
  } seq_state_t;

  // One entry written into the result FIFO.
  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    logic [RESULT_W-1:0] result;
  } fifo_entry_t;

endpackage : adc_seq_pkg

// >>> design/adc_clk_prescaler.sv
// Prescaler that turns the core clock into converter clock ticks.
// Assumes run is held high for the whole sample and conversion span.
`timescale 1ns/1ps
module adc_clk_prescaler
  import adc_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [adc_seq_pkg::PRESCALE_W-1:0] prescale,
  output logic tick
);

  import adc_seq_pkg::*;

  logic [PRESCALE_W:0] div_cnt_r;
  logic [PRESCALE_W:0] div_cnt_nxt;
  logic [PRESCALE_W:0] div_eff;

  // Clamp the divide so a converter period is never shorter than allowed.
  function automatic logic [PRESCALE_W:0] clamp_div(
    input logic [PRESCALE_W-1:0] p);
    logic [PRESCALE_W:0] d;
    d = {1'b0, p} + (PRESCALE_W+1)'(1);
    if (d < (PRESCALE_W+1)'(ADC_DIV_MIN)) begin
      d = (PRESCALE_W+1)'(ADC_DIV_MIN);
    end
    return d;
  endfunction : clamp_div

  // The count restarts whenever run drops so each phase sees whole periods.
  always_comb begin
    div_eff = clamp_div(prescale);
    tick = run && (div_cnt_r == div_eff - (PRESCALE_W+1)'(1));
    if (!run || tick) begin
      div_cnt_nxt = '0;
    end else begin
      div_cnt_nxt = div_cnt_r + (PRESCALE_W+1)'(1);
    end
  end

  // Registers the divide counter.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

endmodule : adc_clk_prescaler

// >>> design/adc_conversion_sequencer.sv
// Start, sample-and-hold, conversion and result load sequencing.
// Assumes the analog core presents its result on adc_raw_data by the last
// conversion cycle and that all inputs are synchronous to core_clk.
`timescale 1ns/1ps
// Function
// - Any of four start sources begins a sequence.
// - Sample-and-hold starts at least three core periods after start.
// - Sample-and-hold lasts at least three converter periods.
// - Conversion lasts at least ten converter periods.
// - Result enters the FIFO two core periods after conversion ends.
// - Interrupt follows a rise of the completion flag by two core periods; none if the flag stays set.
// - Whole sequence takes at least 900 ns.
// - Every result is 10 bits wide.
// - One of eight input channels is selected per conversion.
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic immediate_start_bit,
  input wire logic start_conversion_request,
  input wire logic ext_start_pin,
  input wire logic event_manager_start,
  input wire logic [adc_seq_pkg::CHAN_W-1:0] channel_select,
  input wire logic [adc_seq_pkg::PRESCALE_W-1:0] prescale,
  input wire logic [adc_seq_pkg::RESULT_W-1:0] adc_raw_data,
  input wire logic flag_clear,
  output logic [adc_seq_pkg::CHAN_W-1:0] analog_channel_sel,
  output logic sample_hold_active,
  output logic convert_active,
  output logic busy,
  output logic fifo_wr_valid,
  output adc_seq_pkg::fifo_entry_t fifo_wr_data,
  output logic completion_flag,
  output logic conversion_interrupt
);

  import adc_seq_pkg::*;

  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [CNT_W-1:0] phase_cnt_r;
  logic [CNT_W-1:0] phase_cnt_nxt;
  logic [CNT_W-1:0] total_cnt_r;
  logic [CNT_W-1:0] total_cnt_nxt;
  logic [CHAN_W-1:0] chan_r;
  logic [CHAN_W-1:0] chan_nxt;
  logic [RESULT_W-1:0] result_r;
  logic [RESULT_W-1:0] result_nxt;
  logic fifo_valid_r;
  logic fifo_valid_nxt;
  fifo_entry_t fifo_data_r;
  fifo_entry_t fifo_data_nxt;
  logic flag_r;
  logic flag_nxt;
  logic flag_rise_r;
  logic flag_rise_nxt;
  logic [IRQ_DELAY_CYC-1:0] irq_pipe_r;
  logic [IRQ_DELAY_CYC-1:0] irq_pipe_nxt;
  logic start_any;
  logic tick;
  logic conv_span_ok;

  // Converter clock ticks run only during sample-and-hold and conversion.
  adc_clk_prescaler u_prescaler (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run((state_r == ST_SAMPLE) || (state_r == ST_CONVERT)),
    .prescale(prescale),
    .tick(tick)
  );

  // Any of the four sources counts as a start request.
  assign start_any = immediate_start_bit || start_conversion_request ||
                     ext_start_pin || event_manager_start;

  // Conversion may end only once the whole span reaches its minimum.
  assign conv_span_ok = total_cnt_r >=
    CNT_W'(SEQ_MIN_CYC - EOC_DELAY_CYC);

  // Next-state logic for the sequencer and its captured data.
  always_comb begin
    state_nxt = state_r;
    phase_cnt_nxt = phase_cnt_r;
    total_cnt_nxt = total_cnt_r + CNT_W'(1);
    chan_nxt = chan_r;
    result_nxt = result_r;
    fifo_valid_nxt = 1'b0;
    fifo_data_nxt = fifo_data_r;
    unique case (state_r)
      ST_IDLE: begin
        total_cnt_nxt = '0;
        if (start_any) begin
          state_nxt = ST_START_DLY;
          phase_cnt_nxt = '0;
          total_cnt_nxt = CNT_W'(1);
          chan_nxt = channel_select;
        end
      end
      ST_START_DLY: begin
        phase_cnt_nxt = phase_cnt_r + CNT_W'(1);
        if (phase_cnt_r == CNT_W'(SOC_DELAY_CYC - 1)) begin
          state_nxt = ST_SAMPLE;
          phase_cnt_nxt = '0;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          phase_cnt_nxt = phase_cnt_r + CNT_W'(1);
          if (phase_cnt_r == CNT_W'(SH_TICKS - 1)) begin
            state_nxt = ST_CONVERT;
            phase_cnt_nxt = '0;
          end
        end
      end
      ST_CONVERT: begin
        if (tick && phase_cnt_r < CNT_W'(CONV_TICKS)) begin
          phase_cnt_nxt = phase_cnt_r + CNT_W'(1);
        end
        if (phase_cnt_r >= CNT_W'(CONV_TICKS) && conv_span_ok) begin
          state_nxt = ST_EOC_DLY;
          phase_cnt_nxt = '0;
          result_nxt = adc_raw_data;
        end
      end
      ST_EOC_DLY: begin
        phase_cnt_nxt = phase_cnt_r + CNT_W'(1);
        if (phase_cnt_r == CNT_W'(EOC_DELAY_CYC - 2)) begin
          state_nxt = ST_IDLE;
          fifo_valid_nxt = 1'b1;
          fifo_data_nxt.channel = chan_r;
          fifo_data_nxt.result = result_r;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        phase_cnt_nxt = '0;
      end
    endcase
  end

  // Flag sets with the FIFO write; a set in the clearing cycle wins.
  // The rise is registered first so the interrupt trails the visible flag.
  always_comb begin
    flag_nxt = flag_r;
    if (flag_clear) begin
      flag_nxt = 1'b0;
    end
    if (fifo_valid_nxt) begin
      flag_nxt = 1'b1;
    end
    flag_rise_nxt = flag_nxt && !flag_r;
    irq_pipe_nxt = {irq_pipe_r[IRQ_DELAY_CYC-2:0], flag_rise_r};
  end

  // Registers all sequencer state.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      phase_cnt_r <= '0;
      total_cnt_r <= '0;
      chan_r <= '0;
      result_r <= '0;
      fifo_valid_r <= 1'b0;
      fifo_data_r <= '0;
      flag_r <= 1'b0;
      flag_rise_r <= 1'b0;
      irq_pipe_r <= '0;
    end else begin
      state_r <= state_nxt;
      phase_cnt_r <= phase_cnt_nxt;
      total_cnt_r <= total_cnt_nxt;
      chan_r <= chan_nxt;
      result_r <= result_nxt;
      fifo_valid_r <= fifo_valid_nxt;
      fifo_data_r <= fifo_data_nxt;
      flag_r <= flag_nxt;
      flag_rise_r <= flag_rise_nxt;
      irq_pipe_r <= irq_pipe_nxt;
    end
  end

  // Outputs come straight from registers or from decoded state.
  assign analog_channel_sel = chan_r;
  assign sample_hold_active = (state_r == ST_SAMPLE);
  assign convert_active = (state_r == ST_CONVERT);
  assign busy = (state_r != ST_IDLE);
  assign fifo_wr_valid = fifo_valid_r;
  assign fifo_wr_data = fifo_data_r;
  assign completion_flag = flag_r;
  assign conversion_interrupt = irq_pipe_r[IRQ_DELAY_CYC-1];

  // Helper counters: cycles spent in the current phase and since start.
  logic [CNT_W-1:0] chk_phase_r;
  logic [CNT_W-1:0] chk_span_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_phase_r <= '0;
      chk_span_r <= '0;
    end else begin
      chk_phase_r <= (state_nxt != state_r) ? '0 : chk_phase_r + CNT_W'(1);
      chk_span_r <= (state_r == ST_IDLE) ? '0 : chk_span_r + CNT_W'(1);
    end
  end

  property p_start_delay;
    @(posedge core_clk) disable iff (!rst_n)
    (state_r == ST_IDLE && start_any) |=>
      (state_r == ST_START_DLY) [*3] ##1 (state_r == ST_SAMPLE);
  endproperty
  a_start_delay: assert property (p_start_delay)
    else $error("Sample phase did not follow start after three cycles.");

  property p_sample_len;
    @(posedge core_clk) disable iff (!rst_n)
    (state_r == ST_SAMPLE && state_nxt == ST_CONVERT) |->
      chk_phase_r >= CNT_W'(SH_TICKS * ADC_DIV_MIN - 1);
  endproperty
  a_sample_len: assert property (p_sample_len)
    else $error("Sample-and-hold phase was too short.");

  property p_convert_len;
    @(posedge core_clk) disable iff (!rst_n)
    (state_r == ST_CONVERT && state_nxt == ST_EOC_DLY) |->
      chk_phase_r >= CNT_W'(CONV_TICKS * ADC_DIV_MIN - 1);
  endproperty
  a_convert_len: assert property (p_convert_len)
    else $error("Conversion phase was too short.");

  property p_eoc_load;
    @(posedge core_clk) disable iff (!rst_n)
    (state_r == ST_CONVERT && state_nxt == ST_EOC_DLY) |->
      ##1 !fifo_valid_r ##1 fifo_valid_r;
  endproperty
  a_eoc_load: assert property (p_eoc_load)
    else $error("Result not loaded two cycles after conversion end.");

  property p_irq_delay;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(flag_r) |-> !conversion_interrupt ##2 conversion_interrupt;
  endproperty
  a_irq_delay: assert property (p_irq_delay)
    else $error("Interrupt did not follow the flag by two cycles.");

  property p_total_span;
    @(posedge core_clk) disable iff (!rst_n)
    (state_r == ST_EOC_DLY && state_nxt == ST_IDLE) |->
      chk_span_r >= CNT_W'(SEQ_MIN_CYC - 2);
  endproperty
  a_total_span: assert property (p_total_span)
    else $error("Whole sequence was shorter than its minimum.");

  property p_result;
    @(posedge core_clk) disable iff (!rst_n)
    (state_r == ST_CONVERT && state_nxt == ST_EOC_DLY) |->
      ##2 (fifo_wr_data.result == $past(adc_raw_data, 2));
  endproperty
  a_result: assert property (p_result)
    else $error("Loaded result differs from the converted value.");

  property p_channel;
    @(posedge core_clk) disable iff (!rst_n)
    (state_r == ST_IDLE && start_any) |=>
      (analog_channel_sel == $past(channel_select)) && busy;
  endproperty
  a_channel: assert property (p_channel)
    else $error("Selected channel was not taken at start.");

  property p_flag_with_load;
    @(posedge core_clk) disable iff (!rst_n)
    fifo_valid_r |-> flag_r;
  endproperty
  a_flag_with_load: assert property (p_flag_with_load)
    else $error("Completion flag not set with the FIFO write.");

  property p_ignore_start;
    @(posedge core_clk) disable iff (!rst_n)
    (state_r == ST_SAMPLE && start_any) |=>
      (state_r == ST_SAMPLE || state_r == ST_CONVERT) &&
      $stable(analog_channel_sel);
  endproperty
  a_ignore_start: assert property (p_ignore_start)
    else $error("Start request disturbed a running sequence.");

endmodule : adc_conversion_sequencer

// >>> sim/analog_core_model.sv
// Behavioural analog core that answers the sequencer's conversions.
// Assumes the bench supplies the sample value on base before each start.
`timescale 1ns/1ps
module analog_core_model
  import adc_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic convert_active,
  input wire logic [adc_seq_pkg::CHAN_W-1:0] analog_channel_sel,
  input wire logic [adc_seq_pkg::RESULT_W-1:0] base,
  output logic [adc_seq_pkg::RESULT_W-1:0] adc_raw_data
);
  // The value follows the selected channel during conversion; otherwise the
  // lines toggle every cycle so that a stale sample cannot pass as a result.
  initial begin
    adc_raw_data = '0;
    forever begin
      @(posedge core_clk);
      if (convert_active) begin
        adc_raw_data <= base + RESULT_W'(analog_channel_sel);
      end else begin
        adc_raw_data <= ~adc_raw_data;
      end
    end
  end
endmodule : analog_core_model

// >>> sim/adc_conversion_sequencer_tb.sv
// Self-checking bench for the converter sequencer, one run per channel.
// Assumes the analog core model and the sequencer design are compiled first.
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
  import adc_seq_pkg::*;
  logic core_clk, rst_n, flag_clear, busy, fifo_wr_valid;
  logic sample_hold_active, convert_active;
  logic completion_flag, conversion_interrupt;
  logic [3:0] src;
  logic [CHAN_W-1:0] channel_select, analog_channel_sel;
  logic [PRESCALE_W-1:0] prescale;
  logic [RESULT_W-1:0] adc_raw_data, base;
  fifo_entry_t fifo_wr_data;
  fifo_entry_t exp_q[$];
  logic [31:0] lfsr;
  int mismatches, total_checks;

  adc_conversion_sequencer dut (
    .core_clk(core_clk), .rst_n(rst_n),
    .immediate_start_bit(src[0]), .start_conversion_request(src[1]),
    .ext_start_pin(src[2]), .event_manager_start(src[3]),
    .channel_select(channel_select), .prescale(prescale),
    .adc_raw_data(adc_raw_data), .flag_clear(flag_clear),
    .analog_channel_sel(analog_channel_sel),
    .sample_hold_active(sample_hold_active),
    .convert_active(convert_active), .busy(busy),
    .fifo_wr_valid(fifo_wr_valid), .fifo_wr_data(fifo_wr_data),
    .completion_flag(completion_flag),
    .conversion_interrupt(conversion_interrupt)
  );

  analog_core_model u_core (
    .core_clk(core_clk), .convert_active(convert_active),
    .analog_channel_sel(analog_channel_sel), .base(base),
    .adc_raw_data(adc_raw_data)
  );

  // Free-running 50 MHz core clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Feedback shift register step for repeatable random settings.
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic fail(input string msg);
    mismatches++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : fail

  task automatic check_bit(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) fail(m);
  endtask : check_bit

  task automatic check_entry(input fifo_entry_t got, input fifo_entry_t exp);
    total_checks++;
    if (got !== exp) fail("result entry");
  endtask : check_entry

  task automatic check_cyc(input int got, input int lo, input int hi,
                           input string m);
    total_checks++;
    if (got < lo || got > hi) fail(m);
  endtask : check_cyc

  // One sequence from source s on channel ch, with a second start injected
  // mid-run; every phase length is measured in core cycles after the start.
  task automatic run_seq(input int s, input int ch, input bit clr);
    int d, sh0, shn, cvn, cvl, vn, irqn, nv;
    fifo_entry_t e, got;
    sh0 = 0; shn = 0; cvn = 0; cvl = 0; vn = 0; irqn = 0; nv = 0;
    lfsr = lfsr_next(lfsr);
    prescale = PRESCALE_W'(2 + lfsr[3:0] % 14);
    d = int'(prescale) + 1;
    base = lfsr[13:4];
    channel_select = CHAN_W'(ch);
    e.channel = CHAN_W'(ch);
    e.result = base + RESULT_W'(ch);
    exp_q.push_back(e);
    flag_clear = clr;
    src = 4'h1 << s;
    @(negedge core_clk);
    src = 4'h0;
    flag_clear = 1'b0;
    check_bit(completion_flag, !clr, "flag after clear");
    for (int n = 1; n < 400; n++) begin
      if (n == 10) begin
        src = 4'h1 << ((s + 1) % 4);
        channel_select = CHAN_W'(ch ^ 1);
      end
      if (n == 11) src = 4'h0;
      if (n == 5) begin
        check_bit(analog_channel_sel == ch, 1'b1, "channel");
      end
      if (sample_hold_active === 1'b1) begin
        if (sh0 == 0) sh0 = n;
        shn++;
      end
      if (convert_active === 1'b1) begin
        cvn++;
        cvl = n;
      end
      if (fifo_wr_valid === 1'b1) begin
        nv++;
        if (vn == 0) vn = n;
        got = fifo_wr_data;
        check_bit(completion_flag, 1'b1, "flag with write");
      end
      if (conversion_interrupt === 1'b1 && irqn == 0) irqn = n;
      if (vn != 0 && n >= vn + 4) break;
      @(negedge core_clk);
    end
    if (vn == 0) begin
      fail("no result written");
      test_done;
    end
    check_cyc(sh0, SOC_DELAY_CYC + 1, SOC_DELAY_CYC + 1, "start");
    check_cyc(shn, SH_TICKS * d, 1000, "s/h length");
    check_cyc(cvn, CONV_TICKS * d, 1000, "conv length");
    check_cyc(vn, cvl + EOC_DELAY_CYC, cvl + EOC_DELAY_CYC, "load");
    check_cyc(vn, SEQ_MIN_CYC, 1000, "total span");
    check_cyc(irqn, clr ? vn + IRQ_DELAY_CYC : 0,
              clr ? vn + IRQ_DELAY_CYC : 0, "interrupt");
    check_cyc(nv, 1, 1, "write count");
    check_entry(got, exp_q.pop_front());
    check_bit(busy, 1'b0, "busy after load");
  endtask : run_seq

  // Reset, settle, then one sequence per channel over all four sources.
  initial begin
    rst_n = 1'b0;
    src = 4'h0;
    flag_clear = 1'b0;
    channel_select = '0;
    prescale = 4'h2;
    base = '0;
    lfsr = 32'h622B;
    mismatches = 0;
    total_checks = 0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    repeat (SETTLE_US * 1000 / CORE_CLK_NS) @(negedge core_clk);
    for (int i = 0; i < 8; i++) begin
      run_seq(i % 4, i, i != 3);
    end
    test_done;
  end
endmodule : adc_conversion_sequencer_tb
